// >>> sirq_pkg.sv
// Shared constants and carrier types for the six-source interrupt controller
package sirq_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [15:0] SIRQ_ADDR_ENABLE = 16'h000F;
  localparam logic [15:0] SIRQ_ADDR_FLAG   = 16'h0010;
  localparam logic [15:0] SIRQ_ADDR_CLEAR  = 16'h0011;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SIRQ_NSRC      = 6;
  localparam int SIRQ_BIT_VSYNC = 0;
  localparam int SIRQ_BIT_EXT   = 1;
  localparam int SIRQ_BIT_TIMER = 2;
  localparam int SIRQ_BIT_ADDR  = 3;
  localparam int SIRQ_BIT_SHIFT = 4;
  localparam int SIRQ_BIT_SCL   = 5;
  localparam int SIRQ_BIT_VOVF  = 6;
  localparam int SIRQ_BIT_HOVF  = 7;

  // ****************************************************
  // Reset values and input conditioning
  // ****************************************************
  localparam logic [5:0] SIRQ_EN_RESET    = 6'h00;
  localparam logic [5:0] SIRQ_FLAG_RESET  = 6'h00;
  localparam logic [7:0] SIRQ_RDATA_RESET = 8'h00;
  localparam int         SIRQ_SYNC_PIN    = 1;
  localparam int         SIRQ_SYNC_NONE   = 0;

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sirq_bus_t;

  typedef struct packed {
    logic [5:0] en;
    logic [5:0] flag;
    logic [7:0] rdata;
    logic       hclr;
    logic       vclr;
  } sirq_state_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       stable;
  } sirq_edge_state_t;

endpackage : sirq_pkg

// >>> sirq_edge.sv
// Edge detector with optional three-stage pin synchroniser
`timescale 1ns/1ns
module sirq_edge
  import sirq_pkg::*;
#(
  parameter int SYNC = 0,
  parameter bit FALL = 1'b0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_sig,
  output logic      o_pulse
);

  sirq_edge_state_t s;
  sirq_edge_state_t next_s;
  logic             src;
  logic             agreed;

  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], i_sig};
    // Pins count a change only once stages two and three agree
    src         = (SYNC != 0) ? s.sync[2] : i_sig;
    agreed      = (SYNC != 0) ? (s.sync[2] == s.sync[1]) : 1'b1;
    o_pulse     = 1'b0;
    if (agreed) begin
      next_s.stable = src;
      o_pulse = (src != s.stable) && (FALL ? !src : src);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : sirq_edge

// >>> sirq_ctrl.sv
// Six-source interrupt flag, enable and clear logic with its register port
`timescale 1ns/1ns

module sirq_ctrl
  import sirq_pkg::*;
(
  input  wire logic      i_sys_clk,
  input  wire logic      i_rst,
  input  wire sirq_bus_t i_bus,
  input  wire logic      i_vsync,
  input  wire logic      i_port1_bit6_pin,
  input  wire logic      i_timer_wrap_evt,
  input  wire logic      i_addr_match_evt,
  input  wire logic      i_shifter_evt,
  input  wire logic      i_scl_pin,
  input  wire logic      i_ddc2b_tx_mode,
  output logic [7:0]     o_rdata,
  output logic           o_irq_req,
  output logic           o_ext_pin_sel,
  output logic           o_hcount_ovf_clear,
  output logic           o_vcount_ovf_clear
);

  // ****************************************************
  // Event capture
  // ****************************************************
  logic [2:0] edge_sig;
  logic [2:0] edge_pulse;
  logic [5:0] evt;
  logic       scl_fall;

  assign edge_sig = {i_scl_pin, i_port1_bit6_pin, i_vsync};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_edge
      sirq_edge #(
        .SYNC (g == 0 ? SIRQ_SYNC_NONE : SIRQ_SYNC_PIN),
        .FALL (g == 2)
      ) u_edge (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_sig     (edge_sig[g]),
        .o_pulse   (edge_pulse[g])
      );
    end
  endgenerate

  // SCL falls only count while the serial block transmits in DDC2B
  assign scl_fall = edge_pulse[2] && i_ddc2b_tx_mode;

  always_comb begin
    evt                 = '0;
    evt[SIRQ_BIT_VSYNC] = edge_pulse[0];
    evt[SIRQ_BIT_EXT]   = edge_pulse[1];
    evt[SIRQ_BIT_TIMER] = i_timer_wrap_evt;
    evt[SIRQ_BIT_ADDR]  = i_addr_match_evt;
    evt[SIRQ_BIT_SHIFT] = i_shifter_evt;
    evt[SIRQ_BIT_SCL]   = scl_fall;
  end

  // ****************************************************
  // Register state
  // ****************************************************
  sirq_state_t s;
  sirq_state_t next_s;
  logic        wr_en;
  logic        wr_clr;
  logic [5:0]  clr_vec;

  assign wr_en  = i_bus.wr && (i_bus.addr == SIRQ_ADDR_ENABLE);
  assign wr_clr = i_bus.wr && (i_bus.addr == SIRQ_ADDR_CLEAR);

  always_comb begin
    next_s      = s;
    next_s.hclr = 1'b0;
    next_s.vclr = 1'b0;
    clr_vec     = wr_clr ? i_bus.wdata[5:0] : 6'h00;
    if (wr_en) begin
      next_s.en = i_bus.wdata[5:0];
    end
    // Set is ORed after the clear so a coincident event survives
    next_s.flag = (s.flag & ~clr_vec) | evt;
    if (wr_clr) begin
      next_s.hclr = i_bus.wdata[SIRQ_BIT_HOVF];
      next_s.vclr = i_bus.wdata[SIRQ_BIT_VOVF];
    end
    // Write-only registers and holes read as zero
    if (i_bus.rd) begin
      next_s.rdata = (i_bus.addr == SIRQ_ADDR_FLAG) ? {2'b00, s.flag} : 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s.en    <= SIRQ_EN_RESET;
      s.flag  <= SIRQ_FLAG_RESET;
      s.rdata <= SIRQ_RDATA_RESET;
      s.hclr  <= 1'b0;
      s.vclr  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // A level request: the CPU samples it between instructions and masks
  // itself while servicing, so no handshake is needed here
  assign o_irq_req          = |(s.flag & s.en);
  assign o_ext_pin_sel      = s.en[SIRQ_BIT_EXT];
  assign o_rdata            = s.rdata;
  assign o_hcount_ovf_clear = s.hclr;
  assign o_vcount_ovf_clear = s.vclr;

  // ****************************************************
  // Assertions
  // ****************************************************
  property p_flag_set;
    @(posedge i_sys_clk) disable iff (i_rst)
    (evt != 6'h00) |=> ((s.flag & $past(evt)) == $past(evt));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set its flag");

  property p_flag_clear;
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr_clr && ((i_bus.wdata[5:0] & evt) == 6'h00))
      |=> ((s.flag & $past(i_bus.wdata[5:0])) == 6'h00);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("clear write left a flag set");

  property p_flag_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> ((s.flag & $past(s.flag & ~clr_vec)) == $past(s.flag & ~clr_vec));
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without a clear");

  property p_irq_follows;
    @(posedge i_sys_clk) disable iff (i_rst)
    ((evt & s.en) != 6'h00 && !wr_en) |=> o_irq_req;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("enabled event raised no request");

  property p_irq_masked;
    @(posedge i_sys_clk) disable iff (i_rst)
    (s.en == 6'h00) |-> !o_irq_req;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("request with all sources disabled");

  property p_hclr;
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr_clr && i_bus.wdata[SIRQ_BIT_HOVF]) |=> o_hcount_ovf_clear
      ##1 (!o_hcount_ovf_clear || $past(wr_clr && i_bus.wdata[SIRQ_BIT_HOVF]));
  endproperty
  a_hclr: assert property (p_hclr)
    else $error("horizontal overflow clear not a single pulse");

  property p_vclr;
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr_clr && i_bus.wdata[SIRQ_BIT_VOVF]) |=> o_vcount_ovf_clear
      ##1 (!o_vcount_ovf_clear || $past(wr_clr && i_bus.wdata[SIRQ_BIT_VOVF]));
  endproperty
  a_vclr: assert property (p_vclr)
    else $error("vertical overflow clear not a single pulse");

  property p_enable_write;
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_en |=> (s.en == $past(i_bus.wdata[5:0]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write not stored");

  property p_flag_read;
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_bus.rd && i_bus.addr == SIRQ_ADDR_FLAG) |=> (o_rdata == {2'b00, $past(s.flag)});
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag read returned wrong data");

  property p_flag_no_spurious;
    @(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> ((s.flag & ~$past(s.flag) & ~$past(evt)) == 6'h00);
  endproperty
  a_flag_no_spurious: assert property (p_flag_no_spurious)
    else $error("flag rose without its event");

  property p_en_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    !wr_en |=> $stable(s.en);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enables changed without a write");

  property p_rdata_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_bus.rd |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_hole_read;
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_bus.rd && i_bus.addr != SIRQ_ADDR_FLAG) |=> (o_rdata == 8'h00);
  endproperty
  a_hole_read: assert property (p_hole_read)
    else $error("write-only or unmapped read not zero");

  property p_hclr_quiet;
    @(posedge i_sys_clk) disable iff (i_rst)
    !(wr_clr && i_bus.wdata[SIRQ_BIT_HOVF]) |=> !o_hcount_ovf_clear;
  endproperty
  a_hclr_quiet: assert property (p_hclr_quiet)
    else $error("horizontal overflow clear without a write");

  property p_vclr_quiet;
    @(posedge i_sys_clk) disable iff (i_rst)
    !(wr_clr && i_bus.wdata[SIRQ_BIT_VOVF]) |=> !o_vcount_ovf_clear;
  endproperty
  a_vclr_quiet: assert property (p_vclr_quiet)
    else $error("vertical overflow clear without a write");

  property p_ext_sel;
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_en |=> (o_ext_pin_sel == $past(i_bus.wdata[SIRQ_BIT_EXT]));
  endproperty
  a_ext_sel: assert property (p_ext_sel)
    else $error("pin select does not follow its enable");

  property p_scl_gated;
    @(posedge i_sys_clk) disable iff (i_rst)
    (!i_ddc2b_tx_mode && !s.flag[SIRQ_BIT_SCL]) |=> !s.flag[SIRQ_BIT_SCL];
  endproperty
  a_scl_gated: assert property (p_scl_gated)
    else $error("clock-low flag set outside transmit mode");

  property p_irq_clear;
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr_clr && !wr_en && evt == 6'h00 && (s.flag & s.en & ~i_bus.wdata[5:0]) == 6'h00)
      |=> !o_irq_req;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("request stayed after its flags were cleared");

  property p_vsync_set;
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(i_vsync) |=> s.flag[SIRQ_BIT_VSYNC];
  endproperty
  a_vsync_set: assert property (p_vsync_set)
    else $error("vsync rise did not set its flag");

  property p_pin_set;
    @(posedge i_sys_clk) disable iff (i_rst)
    edge_pulse[1] |=> s.flag[SIRQ_BIT_EXT];
  endproperty
  a_pin_set: assert property (p_pin_set)
    else $error("pin edge did not set its flag");

  property p_timer_set;
    @(posedge i_sys_clk) disable iff (i_rst)
    i_timer_wrap_evt |=> s.flag[SIRQ_BIT_TIMER];
  endproperty
  a_timer_set: assert property (p_timer_set)
    else $error("timer wrap did not set its flag");

  property p_addr_set;
    @(posedge i_sys_clk) disable iff (i_rst)
    i_addr_match_evt |=> s.flag[SIRQ_BIT_ADDR];
  endproperty
  a_addr_set: assert property (p_addr_set)
    else $error("address match did not set its flag");

  property p_shift_set;
    @(posedge i_sys_clk) disable iff (i_rst)
    i_shifter_evt |=> s.flag[SIRQ_BIT_SHIFT];
  endproperty
  a_shift_set: assert property (p_shift_set)
    else $error("shifter event did not set its flag");

  // ****************************************************
  // Coverage
  // ****************************************************
  c_irq_raised: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(o_irq_req));
  c_ext_pin: cover property (@(posedge i_sys_clk) disable iff (i_rst) edge_pulse[1]);
  c_hclr: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_hcount_ovf_clear);
  c_set_and_clear: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_clr && ((i_bus.wdata[5:0] & evt) != 6'h00));
  c_scl_fall: cover property (@(posedge i_sys_clk) disable iff (i_rst) scl_fall);

endmodule : sirq_ctrl

// >>> sirq_cpu_model.sv
// CPU-side bus master and interrupt service model for the interrupt controller
`timescale 1ns/1ns
module sirq_cpu_model
  import sirq_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  output sirq_bus_t       o_bus
);
  initial begin
    o_bus = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 8'h00};
  end

  // ****************************************************
  // Bus cycles, launched and released on the falling edge
  // ****************************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_bus.wr = 1'b1;
    o_bus.addr = a;
    o_bus.wdata = d;
    @(negedge i_sys_clk);
    o_bus.wr = 1'b0;
    // Released lines must not keep looking valid
    o_bus.addr = ~a;
    o_bus.wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_bus.rd = 1'b1;
    o_bus.addr = a;
    @(negedge i_sys_clk);
    o_bus.rd = 1'b0;
    o_bus.addr = ~a;
    d = i_rdata;
  endtask : rd

  // ****************************************************
  // Handler: lowest pending source first, a software choice
  // ****************************************************
  task automatic service(output int src);
    logic [7:0] f;
    rd(SIRQ_ADDR_FLAG, f);
    src = SIRQ_NSRC;
    for (int i = SIRQ_NSRC - 1; i >= 0; i--) begin
      if (f[i]) src = i;
    end
    if (src < SIRQ_NSRC) wr(SIRQ_ADDR_CLEAR, 8'h01 << src);
  endtask : service
endmodule : sirq_cpu_model

// >>> sirq_ctrl_tb.sv
// Self-checking testbench for the six-source interrupt controller
`timescale 1ns/1ns
module sirq_ctrl_tb
  import sirq_pkg::*;
;
  logic       i_sys_clk, i_rst, vsync, pin, tmr, amatch, shift, scl, txm;
  logic       irq, ext_sel, hclr, vclr;
  logic [7:0] rdata, rv;
  sirq_bus_t  bus;
  int         fail_count, checked, cycles, src;

  sirq_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus(bus), .i_vsync(vsync),
    .i_port1_bit6_pin(pin), .i_timer_wrap_evt(tmr), .i_addr_match_evt(amatch),
    .i_shifter_evt(shift), .i_scl_pin(scl), .i_ddc2b_tx_mode(txm), .o_rdata(rdata),
    .o_irq_req(irq), .o_ext_pin_sel(ext_sel), .o_hcount_ovf_clear(hclr),
    .o_vcount_ovf_clear(vclr));
  sirq_cpu_model cpu (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_bus(bus));

  // ****************************************************
  // Checking and closing
  // ****************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************************
  // Scenarios
  // ****************************************************
  initial begin
    {i_rst, vsync, pin, tmr, amatch, shift, scl, txm} = 8'h82;
    repeat (3) @(negedge i_sys_clk);
    i_rst = 1'b0;
    cpu.rd(SIRQ_ADDR_FLAG, rv);
    chk(rv, 8'h00);
    chk(8'(irq), 8'h00);
    // SCL fall outside transmit mode
    scl = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    scl = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    cpu.rd(SIRQ_ADDR_FLAG, rv);
    chk(rv, 8'h00);
    // Every event with all enables off; falling edges of vsync and pin must not count
    txm = 1'b1;
    {vsync, pin, tmr, amatch, shift, scl} = 6'h3E;
    @(negedge i_sys_clk);
    {tmr, amatch, shift} = 3'h0;
    repeat (6) @(negedge i_sys_clk);
    {vsync, pin} = 2'h0;
    repeat (6) @(negedge i_sys_clk);
    cpu.wr(SIRQ_ADDR_CLEAR, 8'h00);
    cpu.wr(16'h0012, 8'hFF);
    cpu.rd(SIRQ_ADDR_FLAG, rv);
    chk(rv, 8'h3F);
    chk(8'(irq), 8'h00);
    cpu.rd(SIRQ_ADDR_ENABLE, rv);
    chk(rv, 8'h00);
    // Timer event in the very cycle of its clear
    fork
      cpu.wr(SIRQ_ADDR_CLEAR, 8'h04);
      begin
        @(negedge i_sys_clk);
        tmr = 1'b1;
        @(negedge i_sys_clk);
        tmr = 1'b0;
      end
    join
    cpu.rd(SIRQ_ADDR_FLAG, rv);
    chk(rv, 8'h3F);
    cpu.wr(SIRQ_ADDR_CLEAR, 8'hC0);
    chk(8'({hclr, vclr}), 8'h03);
    @(negedge i_sys_clk);
    chk(8'({hclr, vclr}), 8'h00);
    cpu.wr(SIRQ_ADDR_ENABLE, 8'h3F);
    chk(8'(ext_sel), 8'h01);
    for (int i = 0; i < SIRQ_NSRC; i++) begin
      chk(8'(irq), 8'h01);
      cpu.service(src);
      chk(8'(src), 8'(i));
    end
    chk(8'(irq), 8'h00);
    cpu.rd(SIRQ_ADDR_FLAG, rv);
    chk(rv, 8'h00);
    finish_test();
  end
endmodule : sirq_ctrl_tb
